// [src/ue_engine.sv]
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ue_map.svh"
module ue_engine
	import ue_pkg::*;
#(
	parameter int NUM_EP = `UE_NUM_EP,
	parameter int EP_SIZE = `UE_EP_SIZE
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ue_sie_in_t sie_in,
	output ue_sie_out_t sie_out
);
	localparam int EPW = $clog2(NUM_EP);
	localparam int IW = $clog2(EP_SIZE);
	localparam int AW = EPW + 1 + IW;
	localparam logic [`UE_CNT_W-1:0] EPS = `UE_CNT_W'(EP_SIZE);

	typedef struct packed {
		ue_ep_t [NUM_EP-1:0] ep;
		logic [EPW-1:0] sel;
		logic sof_flag;
		logic eor_flag;
		logic [`UE_FN_W-1:0] fnum;
		logic crc_good;
		logic crc_bad;
		ue_usb_st_t st;
		logic [EPW-1:0] cur;
		logic bank;
		logic setup;
		logic iso;
		logic [`UE_CNT_W-1:0] idx;
		logic tx_pend;
		logic tx_have;
		logic hs_valid;
		ue_hs_t hs_kind;
		ue_apb_t apb;
	} ue_state_t;

	localparam ue_state_t RST = '0;

	// Refuse sizes the bank addressing cannot serve
	if (NUM_EP < 2 || NUM_EP > `UE_MAX_EP || EP_SIZE < 2 || (1 << IW) != EP_SIZE
			|| EP_SIZE >= (1 << `UE_CNT_W)) begin : g_bad_param
		$error("ue_engine: unsupported NUM_EP or EP_SIZE");
	end

	ue_state_t s, n;
	ue_ep_t ce, fe, te;
	ue_apb_t apb_keep;
	logic ce_full, usb_we, usb_re, access, is_data, mapped, fin_in, tx_valid, tx_last, tb;
	logic tok_ok;
	logic [EPW-1:0] tep;
	logic [`UE_CNT_W-1:0] ce_len;
	logic [31:0] rd_word;
	logic mem_we, mem_re;
	logic [AW-1:0] mem_waddr, mem_raddr;
	logic [7:0] mem_wdata, mem_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Derived views of the current, selected and addressed endpoints
	assign ce = s.ep[s.cur];
	assign fe = s.ep[s.sel];
	assign tep = sie_in.tok_ep[EPW-1:0];
	assign te = s.ep[tep];
	assign tok_ok = {1'b0, sie_in.tok_ep} < 5'(NUM_EP) && te.en;
	assign tb = te.pingpong ? te.usb_bank : 1'b0;
	assign ce_full = s.bank ? ce.rx1 : ce.rx0;
	assign ce_len = s.bank ? ce.cnt1 : ce.cnt0;
	// Full bank drops bytes; late clear keeps the rest; excess dropped
	assign usb_we = s.st == U_RX && sie_in.rx_valid && (s.setup || !ce_full)
		&& s.idx < EPS;
	assign usb_re = s.st == U_TX && !s.tx_have && !s.tx_pend && s.idx < ce_len;
	assign tx_valid = s.st == U_TX && (s.tx_have || ce_len == '0);
	assign tx_last = ce_len == '0 || s.idx == ce_len - `UE_CNT_W'(1);
	assign access = psel && penable;
	assign is_data = paddr == `UE_A_DATA;

	////////////////////////////////////////////////////////////////////////////////
	// Register read decode
	always_comb begin
		rd_word = '0;
		mapped = 1'b1;
		case (paddr)
			`UE_A_SEL: rd_word[EPW-1:0] = s.sel;
			`UE_A_STAT: begin
				rd_word[`UE_S_TXDONE] = fe.tx_done;
				rd_word[`UE_S_RX0] = fe.rx0;
				rd_word[`UE_S_SETUP] = fe.setup;
				rd_word[`UE_S_STALL_REQUEST] = fe.stall_req;
				rd_word[`UE_S_TX_READY] = |fe.tx_ready;
				rd_word[`UE_S_STALL_OR_CRC_FLAG] = fe.stall_crc;
				rd_word[`UE_S_RX1] = fe.rx1;
				rd_word[`UE_S_DIR] = fe.dir;
				rd_word[`UE_S_TOGGLE] = fe.toggle;
			end
			`UE_A_CFG: begin
				rd_word[`UE_C_TYPE_HI:`UE_C_TYPE_LO] = fe.kind;
				rd_word[`UE_C_IN] = fe.ep_in;
				rd_word[`UE_C_PP] = fe.pingpong;
				rd_word[`UE_C_EN] = fe.en;
			end
			`UE_A_CNT: rd_word[`UE_CNT_W-1:0] = fe.fw_bank ? fe.cnt1 : fe.cnt0;
			`UE_A_EVT: begin
				rd_word[`UE_E_SOF] = s.sof_flag;
				rd_word[`UE_E_EOR] = s.eor_flag;
			end
			// Frame field split over low byte and high bits
			`UE_A_FNL: rd_word[`UE_F_HI_LO-1:0] = s.fnum[`UE_F_HI_LO-1:0];
			`UE_A_FNH: begin
				rd_word[`UE_F_HI_HI-`UE_F_HI_LO:0] = s.fnum[`UE_F_HI_HI:`UE_F_HI_LO];
				rd_word[`UE_F_FRAME_CRC_BAD] = s.crc_bad;
				rd_word[`UE_F_FRAME_CRC_GOOD] = s.crc_good;
			end
			`UE_A_EPRST, `UE_A_DATA: rd_word = '0;
			default: mapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: bus accesses first so hardware sets win over clears
	always_comb begin
		n = s;
		n.hs_valid = 1'b0;
		pready = 1'b0;
		pslverr = 1'b0;
		mem_we = 1'b0;
		mem_waddr = {s.sel, fe.fw_bank, fe.fw_ptr[IW-1:0]};
		mem_wdata = pwdata[7:0];
		mem_re = 1'b0;
		mem_raddr = {s.sel, fe.fw_bank, fe.fw_ptr[IW-1:0]};
		fin_in = 1'b0;
		apb_keep = '0;
		if (access && !mapped) begin
			pready = 1'b1;
			pslverr = 1'b1;
		end else if (access && pwrite && !(is_data && usb_we)) begin
			pready = 1'b1;
			case (paddr)
				`UE_A_SEL: n.sel = pwdata[EPW-1:0];
				`UE_A_CFG: begin
					n.ep[s.sel].kind = ue_ep_type_t'(pwdata[`UE_C_TYPE_HI:`UE_C_TYPE_LO]);
					n.ep[s.sel].ep_in = pwdata[`UE_C_IN];
					n.ep[s.sel].pingpong = pwdata[`UE_C_PP];
					n.ep[s.sel].en = pwdata[`UE_C_EN];
				end
				`UE_A_STAT: begin
					n.ep[s.sel].dir = pwdata[`UE_S_DIR];
					n.ep[s.sel].stall_req = pwdata[`UE_S_STALL_REQUEST];
					// Hardware flags clear on a written zero
					if (!pwdata[`UE_S_TXDONE]) n.ep[s.sel].tx_done = 1'b0;
					if (!pwdata[`UE_S_SETUP]) n.ep[s.sel].setup = 1'b0;
					if (!pwdata[`UE_S_STALL_OR_CRC_FLAG]) n.ep[s.sel].stall_crc = 1'b0;
					// Bank 0 release swaps banks in ping-pong
					if (fe.rx0 && !pwdata[`UE_S_RX0]) begin
						n.ep[s.sel].rx0 = 1'b0;
						n.ep[s.sel].fw_ptr = '0;
						n.ep[s.sel].fw_bank = fe.pingpong;
					end
					if (fe.rx1 && !pwdata[`UE_S_RX1]) begin
						n.ep[s.sel].rx1 = 1'b0;
						n.ep[s.sel].fw_ptr = '0;
						n.ep[s.sel].fw_bank = 1'b0;
					end
					// Ready arms the filled bank and, in ping-pong, flips to the other one
					if (pwdata[`UE_S_TX_READY] && !fe.tx_ready[fe.fw_bank]) begin
						n.ep[s.sel].tx_ready[fe.fw_bank] = 1'b1;
						if (fe.fw_bank) n.ep[s.sel].cnt1 = fe.fw_ptr;
						else n.ep[s.sel].cnt0 = fe.fw_ptr;
						n.ep[s.sel].fw_bank = fe.fw_bank ^ fe.pingpong;
						n.ep[s.sel].fw_ptr = '0;
					end else if (!pwdata[`UE_S_TX_READY] && |fe.tx_ready) begin
						n.ep[s.sel].tx_ready = '0;
						n.ep[s.sel].fw_ptr = '0;
						n.ep[s.sel].fw_bank = 1'b0;
						n.ep[s.sel].usb_bank = 1'b0;
					end
				end
				`UE_A_DATA: begin
					if (fe.fw_ptr < EPS) begin
						mem_we = 1'b1;
						n.ep[s.sel].fw_ptr = fe.fw_ptr + `UE_CNT_W'(1);
					end
				end
				`UE_A_EPRST: begin
					for (int i = 0; i < NUM_EP; i++) begin
						if (pwdata[i]) begin
							n.ep[i].toggle = 1'b0;
							n.ep[i].tx_ready = '0;
							n.ep[i].rx0 = 1'b0;
							n.ep[i].rx1 = 1'b0;
							n.ep[i].fw_bank = 1'b0;
							n.ep[i].usb_bank = 1'b0;
							n.ep[i].fw_ptr = '0;
						end
					end
				end
				`UE_A_EVT: begin
					if (!pwdata[`UE_E_SOF]) n.sof_flag = 1'b0;
					if (!pwdata[`UE_E_EOR]) n.eor_flag = 1'b0;
				end
				default: ;
			endcase
		end else if (access && !pwrite) begin
			// Reads answer one cycle after the data is caught
			if (s.apb.rd_done) begin
				pready = 1'b1;
				n.apb.rd_done = 1'b0;
				n.apb.rd_mem = 1'b0;
			end else if (!is_data) begin
				n.apb.prdata = rd_word;
				n.apb.rd_done = 1'b1;
			end else if (!usb_re && s.st != U_TX) begin
				mem_re = 1'b1;
				n.apb.rd_done = 1'b1;
				n.apb.rd_mem = 1'b1;
				if (fe.fw_ptr < EPS) n.ep[s.sel].fw_ptr = fe.fw_ptr + `UE_CNT_W'(1);
			end
		end

		// Packet data path
		unique case (s.st)
			U_IDLE: ;
			U_RX: begin
				if (usb_we) begin
					mem_we = 1'b1;
					mem_waddr = {s.cur, s.bank, s.idx[IW-1:0]};
					mem_wdata = sie_in.rx_byte;
					n.idx = s.idx + `UE_CNT_W'(1);
				end
				if (sie_in.rx_eop) begin
					n.st = U_IDLE;
					if (s.setup && sie_in.rx_crc_ok) begin
						// Setup wipes the other status bits and the stall request
						n.ep[s.cur].setup = 1'b1;
						n.ep[s.cur].stall_req = 1'b0;
						n.ep[s.cur].tx_done = 1'b0;
						n.ep[s.cur].rx0 = 1'b0;
						n.ep[s.cur].rx1 = 1'b0;
						n.ep[s.cur].stall_crc = 1'b0;
						n.ep[s.cur].tx_ready = '0;
						n.ep[s.cur].dir = 1'b0;
						n.ep[s.cur].cnt0 = s.idx;
						n.ep[s.cur].fw_ptr = '0;
						n.ep[s.cur].fw_bank = 1'b0;
						n.ep[s.cur].toggle = !sie_in.rx_data1;
						n.hs_valid = 1'b1;
						n.hs_kind = UE_HS_ACK;
					end else if (!s.setup && !ce_full && (s.iso || sie_in.rx_crc_ok)) begin
						if (s.bank) n.ep[s.cur].rx1 = 1'b1;
						else n.ep[s.cur].rx0 = 1'b1;
						if (s.bank) n.ep[s.cur].cnt1 = s.idx;
						else n.ep[s.cur].cnt0 = s.idx;
						if (s.iso) n.ep[s.cur].stall_crc = !sie_in.rx_crc_ok;
						n.ep[s.cur].toggle = !sie_in.rx_data1;
						n.ep[s.cur].usb_bank = s.bank ^ ce.pingpong;
						if (s.bank == ce.fw_bank) n.ep[s.cur].fw_ptr = '0;
						n.hs_valid = !s.iso;
						n.hs_kind = UE_HS_ACK;
					end
				end
			end
			U_TX: begin
				if (usb_re) begin
					mem_re = 1'b1;
					mem_raddr = {s.cur, s.bank, s.idx[IW-1:0]};
					n.tx_pend = 1'b1;
				end
				if (s.tx_pend) begin
					n.tx_pend = 1'b0;
					n.tx_have = 1'b1;
				end
				if (tx_valid && sie_in.tx_take) begin
					n.tx_have = 1'b0;
					n.idx = s.idx + `UE_CNT_W'(1);
					if (tx_last) begin
						// Isochronous completes without a handshake
						fin_in = s.iso;
						n.st = s.iso ? U_IDLE : U_WAIT;
					end
				end
			end
			U_WAIT: begin
				if (sie_in.host_ack) begin
					fin_in = 1'b1;
					n.st = U_IDLE;
				end
			end
		endcase
		if (fin_in) begin
			n.ep[s.cur].tx_ready[s.bank] = 1'b0;
			n.ep[s.cur].tx_done = 1'b1;
			n.ep[s.cur].usb_bank = s.bank ^ ce.pingpong;
		end

		// Tokens; a new token other than frame start also ends any stale transfer
		if (sie_in.tok_valid) begin
			if (sie_in.tok_pid == UE_TOK_SOF) begin
				n.sof_flag = 1'b1;
				n.fnum = sie_in.sof_frame;
				n.crc_good = sie_in.sof_crc_ok;
				n.crc_bad = !sie_in.sof_crc_ok;
			end else begin
				n.st = U_IDLE;
				n.cur = tep;
				n.idx = '0;
				n.tx_pend = 1'b0;
				n.tx_have = 1'b0;
				n.iso = te.kind == UE_EP_ISO;
				n.bank = tb;
				n.setup = 1'b0;
				if (tok_ok && sie_in.tok_pid == UE_TOK_SETUP && te.kind == UE_EP_CTRL) begin
					n.st = U_RX;
					n.bank = 1'b0;
					n.setup = 1'b1;
				// Only control runs both ways; others keep one direction
				end else if (tok_ok && (te.kind == UE_EP_CTRL
						|| te.ep_in == (sie_in.tok_pid == UE_TOK_IN))) begin
					if (te.stall_req && te.kind != UE_EP_ISO) begin
						n.hs_valid = 1'b1;
						n.hs_kind = UE_HS_STALL;
						n.ep[tep].stall_crc = 1'b1;
					end else if (sie_in.tok_pid == UE_TOK_OUT) begin
						if (te.kind == UE_EP_ISO || !(tb ? te.rx1 : te.rx0)) n.st = U_RX;
						else begin
							n.hs_valid = 1'b1;
							n.hs_kind = UE_HS_NAK;
						end
					end else if (te.tx_ready[tb]) begin
						n.st = U_TX;
					end else if (te.kind != UE_EP_ISO) begin
						n.hs_valid = 1'b1;
						n.hs_kind = UE_HS_NAK;
					end
				end
			end
		end

		// End of bus reset returns everything but the bus read in flight
		if (sie_in.reset_end) begin
			apb_keep = n.apb;
			n = RST;
			n.apb = apb_keep;
			n.eor_flag = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	ue_bank_mem #(.AW(AW), .DW(8)) u_mem (
		.clk(clk),
		.resetn(resetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.re(mem_re),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Outputs
	assign prdata = s.apb.rd_mem ? {24'h0, mem_rdata} : s.apb.prdata;
	assign sie_out.hs_valid = s.hs_valid;
	assign sie_out.hs_kind = s.hs_kind;
	assign sie_out.tx_valid = tx_valid;
	assign sie_out.tx_byte = mem_rdata;
	assign sie_out.tx_last = tx_last;
	assign sie_out.tx_empty = ce_len == '0;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	logic sof_tok, iso_in_idle, setup_ok, iso_last;
	assign sof_tok = sie_in.tok_valid && sie_in.tok_pid == UE_TOK_SOF && !sie_in.reset_end;
	assign iso_in_idle = sie_in.tok_valid && sie_in.tok_pid == UE_TOK_IN && tok_ok
		&& te.kind == UE_EP_ISO && te.ep_in && !te.tx_ready[tb] && !sie_in.reset_end;
	assign setup_ok = s.st == U_RX && s.setup && sie_in.rx_eop && sie_in.rx_crc_ok
		&& !sie_in.tok_valid && !sie_in.reset_end;
	assign iso_last = tx_valid && sie_in.tx_take && tx_last && s.iso
		&& !sie_in.tok_valid && !sie_in.reset_end;

	frame_flag_a: assert property (sof_tok |=> s.sof_flag)
		else $error("frame start flag not set");
	frame_field_a: assert property (sof_tok |=> s.fnum == $past(sie_in.sof_frame))
		else $error("frame number not captured");
	frame_crc_a: assert property (sof_tok |=> s.crc_good == $past(sie_in.sof_crc_ok)
		&& s.crc_good != s.crc_bad)
		else $error("frame crc bits wrong");
	bus_reset_a: assert property (sie_in.reset_end |=> s.eor_flag && s.st == U_IDLE
		&& s.sel == '0 && !s.sof_flag)
		else $error("bus reset end mishandled");
	// Store index must not move while the addressed bank is still full
	full_bank_a: assert property (s.st == U_RX && !s.setup && ce_full
		&& !sie_in.tok_valid && !sie_in.reset_end |=> s.idx == $past(s.idx))
		else $error("byte stored into full bank");
	stall_flag_a: assert property (s.hs_valid && s.hs_kind == UE_HS_STALL
		|-> ce.stall_crc && ce.kind != UE_EP_ISO)
		else $error("stall sent without flag");
	setup_wipe_a: assert property (setup_ok |=> ce.setup && !ce.stall_req
		&& !ce.rx0 && !ce.tx_done && !ce.stall_crc && s.hs_valid)
		else $error("setup did not clear status");
	iso_silent_a: assert property (iso_in_idle |=> !s.hs_valid && s.st == U_IDLE
		##1 !sie_out.tx_valid)
		else $error("iso in answered without ready");
	iso_done_a: assert property (iso_last |=> ce.tx_done && s.st == U_IDLE
		&& !s.hs_valid)
		else $error("iso in completion missing");
endmodule

// [src/ue_map.svh]
// Function
// - Control endpoints both ways, others one direction
// - Status stage is opposite-direction zero-length packet
// - Iso OUT sets bank-0 flag and count
// - Iso OUT CRC flag refreshed every accepted packet
// - Iso data into full bank is discarded
// - Late flag clear stores only remaining bytes
// - Excess bytes dropped, packet still valid
// - Ping-pong OUT alternates banks, clear swaps
// - Iso IN without ready sends nothing
// - Iso IN done sets flag without acknowledge
// - Ping-pong IN switches bank on ready
// - Bus reset end sets flag, clears registers
// - Stall request answers next token with STALL, except on iso endpoints
// - STALL sent sets stall flag
// - Valid SETUP clears stall request
// - Frame start sets frame flag
// - Frame capture with CRC good or bad
// - Setup received clears other status bits
// - Toggle set on DATA0, cleared on DATA1
`ifndef UE_MAP_SVH
`define UE_MAP_SVH

// Register offsets
`define UE_A_SEL 8'h00
`define UE_A_STAT 8'h04
`define UE_A_CFG 8'h08
`define UE_A_DATA 8'h0c
`define UE_A_CNT 8'h10
`define UE_A_EPRST 8'h14
`define UE_A_EVT 8'h18
`define UE_A_FNL 8'h1c
`define UE_A_FNH 8'h20

// Endpoint status fields
`define UE_S_TXDONE 0
`define UE_S_RX0 1
`define UE_S_SETUP 2
`define UE_S_STALL_REQUEST 3
`define UE_S_TX_READY 4
`define UE_S_STALL_OR_CRC_FLAG 5
`define UE_S_RX1 6
`define UE_S_DIR 7
`define UE_S_TOGGLE 8

// Endpoint configuration fields
`define UE_C_TYPE_LO 0
`define UE_C_TYPE_HI 1
`define UE_C_IN 2
`define UE_C_PP 3
`define UE_C_EN 7

// Event and frame fields
`define UE_E_SOF 3
`define UE_E_EOR 4
`define UE_F_HI_LO 8
`define UE_F_HI_HI 10
`define UE_F_FRAME_CRC_BAD 4
`define UE_F_FRAME_CRC_GOOD 5

// Sizes
`define UE_NUM_EP 4
`define UE_EP_SIZE 64
`define UE_CNT_W 8
`define UE_FN_W 11
`define UE_MAX_EP 16

`endif

// [src/ue_pkg.sv]
`include "ue_map.svh"
package ue_pkg;
	typedef enum logic [1:0] {UE_EP_CTRL, UE_EP_ISO, UE_EP_BULK, UE_EP_INTR} ue_ep_type_t;
	typedef enum logic [1:0] {UE_TOK_OUT, UE_TOK_IN, UE_TOK_SETUP, UE_TOK_SOF} ue_tok_t;
	typedef enum logic [1:0] {UE_HS_ACK, UE_HS_NAK, UE_HS_STALL} ue_hs_t;
	typedef enum logic [1:0] {U_IDLE, U_RX, U_TX, U_WAIT} ue_usb_st_t;

	// Packet-level events from the serial engine
	typedef struct packed {
		logic tok_valid;
		ue_tok_t tok_pid;
		logic [3:0] tok_ep;
		logic [`UE_FN_W-1:0] sof_frame;
		logic sof_crc_ok;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic rx_eop;
		logic rx_crc_ok;
		logic rx_data1;
		logic tx_take;
		logic host_ack;
		logic reset_end;
	} ue_sie_in_t;

	// Answers to the serial engine
	typedef struct packed {
		logic hs_valid;
		ue_hs_t hs_kind;
		logic tx_valid;
		logic [7:0] tx_byte;
		logic tx_last;
		logic tx_empty;
	} ue_sie_out_t;

	// One endpoint: configuration, flags, bank bookkeeping
	typedef struct packed {
		logic en;
		logic pingpong;
		logic ep_in;
		ue_ep_type_t kind;
		logic dir;
		logic stall_req;
		logic setup;
		logic tx_done;
		logic rx0;
		logic rx1;
		logic stall_crc;
		logic toggle;
		logic [1:0] tx_ready;
		logic fw_bank;
		logic usb_bank;
		logic [`UE_CNT_W-1:0] cnt0;
		logic [`UE_CNT_W-1:0] cnt1;
		logic [`UE_CNT_W-1:0] fw_ptr;
	} ue_ep_t;

	// Bus read pipeline
	typedef struct packed {
		logic rd_done;
		logic rd_mem;
		logic [31:0] prdata;
	} ue_apb_t;
endpackage

// [src/ue_bank_mem.sv]
`timescale 1ns/1ps
// Endpoint bank storage, one write and one registered read port
module ue_bank_mem
	import ue_pkg::*;
#(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Array write
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= '0;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule

// [verification/ue_host_model.sv]
`timescale 1ns/1ps
// Host on the bus: tokens, OUT packets, collection of IN packets
module ue_host_model
	import ue_pkg::*;
(
	input wire logic clk,
	input wire ue_sie_out_t sie_out,
	output ue_sie_in_t sie_in
);
	initial sie_in = '0;

	////////////////////////////////////////////////////////////////
	// Token pulse; frame fields only meaningful with a frame token
	task automatic token(input ue_tok_t pid, input logic [3:0] ep, input logic [10:0] fr,
		input logic ok);
		@(posedge clk);
		sie_in.tok_valid <= 1'b1;
		sie_in.tok_pid <= pid;
		sie_in.tok_ep <= ep;
		sie_in.sof_frame <= fr;
		sie_in.sof_crc_ok <= ok;
		@(posedge clk);
		sie_in.tok_valid <= 1'b0;
		sie_in.sof_frame <= ~fr; // Stale field is not held
		sie_in.sof_crc_ok <= ~ok;
	endtask

	// Token, data bytes back to back, end of packet
	task automatic out_pkt(input ue_tok_t pid, input logic [3:0] ep, input logic [7:0] b[$],
		input logic ok, input logic d1);
		token(pid, ep, 11'h000, 1'b0);
		foreach (b[i]) begin
			sie_in.rx_valid <= 1'b1;
			sie_in.rx_byte <= b[i];
			@(posedge clk);
		end
		sie_in.rx_valid <= 1'b0;
		sie_in.rx_byte <= ~sie_in.rx_byte;
		sie_in.rx_eop <= 1'b1;
		sie_in.rx_crc_ok <= ok;
		sie_in.rx_data1 <= d1;
		@(posedge clk);
		sie_in.rx_eop <= 1'b0;
		sie_in.rx_crc_ok <= ~ok;
		sie_in.rx_data1 <= ~d1;
	endtask

	// Take every offered beat; gives up when nothing is offered
	task automatic take_in(input logic ack);
		int n;
		logic last;
		last = 1'b0;
		while (!last) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (sie_out.tx_valid !== 1'b1 && n < 8);
			if (sie_out.tx_valid !== 1'b1)
				return;
			last = sie_out.tx_last | sie_out.tx_empty;
			@(posedge clk);
			sie_in.tx_take <= 1'b1;
			@(posedge clk);
			sie_in.tx_take <= 1'b0;
		end
		if (ack) begin
			@(posedge clk);
			sie_in.host_ack <= 1'b1;
			@(posedge clk);
			sie_in.host_ack <= 1'b0;
		end
	endtask

	// End of bus reset pulse
	task automatic bus_reset();
		@(posedge clk);
		sie_in.reset_end <= 1'b1;
		@(posedge clk);
		sie_in.reset_end <= 1'b0;
	endtask
endmodule

// [verification/ue_engine_tb.sv]
`timescale 1ns/1ps
module ue_engine_tb;
	import ue_pkg::*;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} ue_exp_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ue_sie_in_t sie_in;
	ue_sie_out_t sie_out;
	ue_exp_t rd_q[$];
	ue_hs_t hs_q[$];
	logic [7:0] tx_q[$];
	logic [7:0] buf_b[$];
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	int seed = 33;

	always #5 clk = ~clk;

	ue_engine DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sie_in(sie_in), .sie_out(sie_out));
	ue_host_model host (.clk(clk), .sie_out(sie_out), .sie_in(sie_in));

	////////////////////////////////////////////////////////////////
	// Verdict and compares
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic cmp_rd(input ue_exp_t x);
		check(((prdata & x.m) === (x.d & x.m)) && pslverr === x.e, "register read");
	endtask

	task automatic cmp_hs(input ue_hs_t h);
		check(sie_out.hs_kind === h, "handshake kind");
	endtask

	task automatic cmp_tx(input logic [7:0] b);
		check(sie_out.tx_byte === b, "IN data byte");
	endtask

	////////////////////////////////////////////////////////////////
	// Monitor: every result takes the oldest note of its kind
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (rd_q.size() == 0)
				check(1'b0, "unexpected read");
			else
				cmp_rd(rd_q.pop_front());
		end
		if (sie_out.hs_valid === 1'b1) begin
			if (hs_q.size() == 0)
				check(1'b0, "unexpected handshake");
			else
				cmp_hs(hs_q.pop_front());
		end
		if (sie_out.tx_valid === 1'b1 && sie_in.tx_take && sie_out.tx_empty !== 1'b1) begin
			if (tx_q.size() == 0)
				check(1'b0, "unexpected IN byte");
			else
				cmp_tx(tx_q.pop_front());
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus master: setup, access held until ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Held until the edge that samples ready; only the hang guard ends a wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic e);
		rd_q.push_back('{d, m, e});
		apb(1'b0, a, 32'h0);
	endtask

	// Random packet contents
	task automatic fill(input int n);
		buf_b.delete();
		repeat (n) buf_b.push_back(8'($random(seed)));
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [10:0] fr;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h04, 32'h0, 32'hffffffff, 1'b0);
		rd(8'h18, 32'h0, 32'hffffffff, 1'b0);
		rd(8'h24, 32'h0, 32'h0, 1'b1);
		$display("test reset and unmapped done");
		// Iso OUT on endpoint 1
		wr(8'h00, 32'h1);
		wr(8'h08, 32'h81);
		fill(3);
		host.out_pkt(UE_TOK_OUT, 4'h1, buf_b, 1'b1, 1'b0);
		rd(8'h04, 32'h002, 32'h0ff, 1'b0);
		rd(8'h10, 32'h3, 32'hffffffff, 1'b0);
		foreach (buf_b[i]) rd(8'h0c, 32'(buf_b[i]), 32'hff, 1'b0);
		fill(5);
		host.out_pkt(UE_TOK_OUT, 4'h1, buf_b, 1'b1, 1'b0);
		rd(8'h10, 32'h3, 32'hffffffff, 1'b0);
		// Armed data on an OUT-only endpoint must not go out on an IN token
		wr(8'h04, 32'h012);
		host.token(UE_TOK_IN, 4'h1, 11'h0, 1'b0);
		host.take_in(1'b0);
		wr(8'h04, 32'h0);
		fill(2);
		host.out_pkt(UE_TOK_OUT, 4'h1, buf_b, 1'b0, 1'b0);
		rd(8'h04, 32'h022, 32'h0ff, 1'b0);
		wr(8'h04, 32'h0);
		fill(66);
		host.out_pkt(UE_TOK_OUT, 4'h1, buf_b, 1'b1, 1'b0);
		rd(8'h04, 32'h002, 32'h0ff, 1'b0);
		rd(8'h10, 32'd64, 32'hffffffff, 1'b0);
		$display("test iso OUT done");
		// Ping-pong iso OUT on endpoint 2
		wr(8'h00, 32'h2);
		wr(8'h08, 32'h89);
		repeat (2) host.out_pkt(UE_TOK_OUT, 4'h2, buf_b, 1'b1, 1'b0);
		rd(8'h04, 32'h042, 32'h0ff, 1'b0);
		wr(8'h04, 32'h040);
		host.out_pkt(UE_TOK_OUT, 4'h2, buf_b, 1'b1, 1'b0);
		rd(8'h04, 32'h042, 32'h0ff, 1'b0);
		$display("test ping-pong OUT done");
		// Ping-pong iso IN on endpoint 3
		wr(8'h00, 32'h3);
		wr(8'h08, 32'h8d);
		host.token(UE_TOK_IN, 4'h3, 11'h0, 1'b0);
		host.take_in(1'b0);
		repeat (2) begin
			fill(2);
			foreach (buf_b[i]) wr(8'h0c, 32'(buf_b[i]));
			foreach (buf_b[i]) tx_q.push_back(buf_b[i]);
			wr(8'h04, 32'h010);
		end
		repeat (2) begin
			host.token(UE_TOK_IN, 4'h3, 11'h0, 1'b0);
			host.take_in(1'b0);
		end
		rd(8'h04, 32'h001, 32'h07f, 1'b0);
		$display("test iso IN done");
		// Control endpoint 0: stall, setup, both status stages
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h80);
		wr(8'h04, 32'h008);
		hs_q.push_back(UE_HS_STALL);
		host.token(UE_TOK_IN, 4'h0, 11'h0, 1'b0);
		rd(8'h04, 32'h028, 32'h1ff, 1'b0);
		wr(8'h04, 32'h008);
		fill(8);
		hs_q.push_back(UE_HS_ACK);
		host.out_pkt(UE_TOK_SETUP, 4'h0, buf_b, 1'b1, 1'b0);
		rd(8'h04, 32'h104, 32'h1ff, 1'b0);
		wr(8'h14, 32'h1);
		wr(8'h04, 32'h084);
		rd(8'h04, 32'h084, 32'h1ff, 1'b0);
		wr(8'h04, 32'h0);
		buf_b.delete();
		hs_q.push_back(UE_HS_ACK);
		host.out_pkt(UE_TOK_OUT, 4'h0, buf_b, 1'b1, 1'b1);
		rd(8'h04, 32'h002, 32'h1ff, 1'b0);
		rd(8'h10, 32'h0, 32'hffffffff, 1'b0);
		wr(8'h04, 32'h0);
		wr(8'h04, 32'h010);
		host.token(UE_TOK_IN, 4'h0, 11'h0, 1'b0);
		host.take_in(1'b1);
		rd(8'h04, 32'h001, 32'h07f, 1'b0);
		$display("test control done");
		// Frame start with good and bad token CRC
		for (int i = 0; i < 2; i++) begin
			fr = 11'($random(seed));
			host.token(UE_TOK_SOF, 4'h0, fr, i == 0);
			rd(8'h18, 32'h008, 32'h008, 1'b0);
			rd(8'h1c, 32'(fr[7:0]), 32'hff, 1'b0);
			rd(8'h20, (i == 0 ? 32'h20 : 32'h10) | 32'(fr[10:8]), 32'h37, 1'b0);
			wr(8'h18, 32'h0);
		end
		$display("test frame start done");
		// End of bus reset
		wr(8'h00, 32'h2);
		host.bus_reset();
		rd(8'h18, 32'h010, 32'h018, 1'b0);
		rd(8'h00, 32'h0, 32'hffffffff, 1'b0);
		rd(8'h08, 32'h0, 32'hffffffff, 1'b0);
		$display("test bus reset done");
		repeat (4) @(posedge clk);
		check(rd_q.size() == 0 && hs_q.size() == 0 && tx_q.size() == 0, "results missing");
		end_of_test();
	end
endmodule
